// ### core/lcsc_pkg.sv
`default_nettype none
package lcsc_pkg;
    // command bytes and ranges
    localparam logic [7:0] CMD_STOP = 8'h01;
    localparam logic [7:0] CMD_DISP_OFF = 8'h08;
    localparam logic [7:0] CMD_DISP_ON = 8'h09;
    localparam logic [7:0] CMD_MODE_LO = 8'h60;
    localparam logic [7:0] CMD_MODE_HI = 8'h6f;
    localparam logic [7:0] CMD_PTR_LO = 8'h80;
    localparam logic [7:0] CMD_PTR_HI = 8'hff;
    // field positions inside a mode command
    localparam int ACC_LSB = 2;
    localparam int DPM_LSB = 0;
    // data processing mode and access mode encodings
    localparam logic [1:0] DPM_AUTO_INC = 2'h0;
    localparam logic [1:0] DPM_AUTO_DEC = 2'h1;
    localparam logic [1:0] ACC_WRITE = 2'h1;
    // drive level codes on the lcd outputs
    localparam logic [1:0] LVL_LO = 2'h0;
    localparam logic [1:0] LVL_HI = 2'h1;
    localparam logic [1:0] LVL_MID = 2'h2;
    // link framing
    localparam logic [2:0] SER_LAST = 3'h7;
    localparam logic [2:0] PAR_LAST = 3'h1;
    // display memory
    localparam int MEM_AW = 7;
    localparam int MEM_DEPTH = 100;
    localparam logic [MEM_AW-1:0] PTR_RESET = 7'h00;
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PROC_TIME_NS = 32;
    localparam int PROC_CYCLES = (PROC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRAME_BITS = 14;
    localparam int SYNC_W = 7;

    typedef struct packed {
        logic par;
        logic cae;
        logic [1:0] chip_addr;
    } lcsc_cfg_t;

    typedef struct packed {
        logic cmd;
        logic [7:0] data;
    } lcsc_byte_t;
endpackage
`default_nettype wire

// ### core/lcsc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module lcsc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ### core/lcsc_mem.sv
`timescale 1ns/100ps
`default_nettype none
module lcsc_mem (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic we,
    input wire logic [lcsc_pkg::MEM_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic re,
    input wire logic [lcsc_pkg::MEM_AW-1:0] raddr,
    output logic [7:0] rdata
);
    // array has no reset: contents survive any reset pulse
    logic [7:0] mem [0:lcsc_pkg::MEM_DEPTH-1];

    always_ff @(posedge clk)
    begin
        if (we && (waddr < lcsc_pkg::MEM_AW'(lcsc_pkg::MEM_DEPTH)))
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata <= 8'h00;
        end
        else if (re && (raddr < lcsc_pkg::MEM_AW'(lcsc_pkg::MEM_DEPTH)))
        begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ### core/lcsc_standby_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module lcsc_standby_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic nibble_strobe_n,
    input wire logic cs_n,
    input wire logic cmd_data_sel,
    input wire logic [3:0] data_in,
    input wire logic chip_addr_pin_low,
    input wire logic chip_addr_pin_high,
    input wire logic reset_in,
    output logic busy_n,
    output logic busy_oe,
    output logic standby,
    output logic lcd_timing_clk_en,
    output logic clk_ctrl_clk_en,
    output logic [1:0] lcd_level,
    output logic [7:0] lcd_col_data,
    output logic [1:0] data_processing_mode_field,
    output logic [1:0] access_mode,
    output logic display_on
);
    typedef enum logic [1:0] {ST_RUN, ST_BUSY, ST_STANDBY} lcsc_state_t;

    function automatic logic in_range(input logic [7:0] b, input logic [7:0] lo, input logic [7:0] hi);
        in_range = (b >= lo) && (b <= hi);
    endfunction

    lcsc_pkg::lcsc_cfg_t cfg_reg;
    lcsc_pkg::lcsc_byte_t link_byte_reg;
    lcsc_state_t state_reg;

    // ---------------- link domain, clocked by the strobe pin ----------------
    logic link_rst_b;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic addr_phase_reg;
    logic [1:0] addr_cmp_reg;
    logic byte_tgl_reg;
    logic last_edge;
    logic need_addr;
    logic addr_take;
    logic selected;
    logic byte_done;
    logic [7:0] full_byte;

    // deselect clears framing; link clock stops outside frames
    assign link_rst_b = rst_b & ~cs_n;
    assign last_edge = cfg_reg.par ? (bit_cnt_reg == lcsc_pkg::PAR_LAST) : (bit_cnt_reg == lcsc_pkg::SER_LAST);
    assign full_byte = cfg_reg.par ? {shift_reg[3:0], data_in} : {shift_reg[6:0], data_in[0]};
    assign need_addr = cfg_reg.par | cfg_reg.cae;
    assign addr_take = addr_phase_reg & need_addr & (cfg_reg.par | last_edge);
    assign selected = (addr_cmp_reg == cfg_reg.chip_addr);
    assign byte_done = last_edge & ~(addr_phase_reg & need_addr) & selected;

    always_ff @(posedge nibble_strobe_n or negedge link_rst_b)
    begin
        if (!link_rst_b)
        begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end
        else
        begin
            shift_reg <= full_byte;
            if ((addr_take && cfg_reg.par) || last_edge)
            begin
                bit_cnt_reg <= 3'h0;
            end
            else
            begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
        end
    end

    // reselect always restarts with an address (one nibble parallel, one byte serial) when addressing is on
    always_ff @(posedge nibble_strobe_n or negedge link_rst_b)
    begin
        if (!link_rst_b)
        begin
            addr_phase_reg <= 1'b1;
            addr_cmp_reg <= 2'h0;
        end
        else if (addr_take)
        begin
            addr_phase_reg <= 1'b0;
            addr_cmp_reg <= cfg_reg.par ? data_in[1:0] : full_byte[1:0];
        end
    end

    // toggle survives deselect so the busy handshake never loses a byte
    always_ff @(posedge nibble_strobe_n or negedge rst_b)
    begin
        if (!rst_b)
        begin
            byte_tgl_reg <= 1'b0;
            link_byte_reg <= '0;
        end
        else if (byte_done)
        begin
            byte_tgl_reg <= ~byte_tgl_reg;
            link_byte_reg <= '{cmd: cmd_data_sel, data: full_byte};
        end
    end

    // ---------------- core domain ----------------
    logic [lcsc_pkg::SYNC_W-1:0] sync_q;
    logic rst_pin_s;
    logic cs_act_s;
    logic strap_cae_s;
    logic strap_par_s;
    logic [1:0] ca_s;
    logic tgl_s;

    lcsc_sync #(
        .W(lcsc_pkg::SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        // select goes in inverted so the cleared sync reads as deselected
        .d({reset_in, ~cs_n, data_in[2], data_in[1], chip_addr_pin_high, chip_addr_pin_low, byte_tgl_reg}),
        .q(sync_q)
    );

    assign {rst_pin_s, cs_act_s, strap_cae_s, strap_par_s, ca_s, tgl_s} = sync_q;

    logic rst_pin_d_reg;
    logic rst_fall;
    logic tgl_seen_reg;
    logic byte_evt;
    logic done_tgl_reg;
    logic [3:0] proc_cnt_reg;
    logic exec;
    logic exec_stop;
    logic in_standby;
    logic [1:0] dp_mode_reg;
    logic [1:0] acc_mode_reg;
    logic [lcsc_pkg::MEM_AW-1:0] ptr_reg;
    logic disp_on_reg;
    logic mem_we;
    logic clk_run;
    logic [lcsc_pkg::FRAME_BITS-1:0] frame_cnt_reg;
    logic alt_phase_reg;
    logic [1:0] lcd_level_reg;

    assign rst_fall = rst_pin_d_reg & ~rst_pin_s;
    assign byte_evt = tgl_s ^ tgl_seen_reg;
    assign exec = (state_reg == ST_BUSY) && (proc_cnt_reg == 4'h0) && !rst_pin_s;
    assign exec_stop = exec && link_byte_reg.cmd && (link_byte_reg.data == lcsc_pkg::CMD_STOP);
    assign in_standby = (state_reg == ST_STANDBY);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_pin_d_reg <= 1'b0;
            tgl_seen_reg <= 1'b0;
        end
        else
        begin
            rst_pin_d_reg <= rst_pin_s;
            tgl_seen_reg <= tgl_s;
        end
    end

    // interface straps caught at the reset pin's fall
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_reg <= '0;
        end
        else if (rst_fall)
        begin
            cfg_reg <= '{par: strap_par_s, cae: strap_cae_s, chip_addr: ca_s};
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_RUN;
        end
        else if (rst_fall && in_standby)
        begin
            state_reg <= ST_RUN;
        end
        else
        begin
            case (state_reg)
                ST_RUN:
                begin
                    if (byte_evt && !rst_pin_s)
                    begin
                        state_reg <= ST_BUSY;
                    end
                end
                ST_BUSY:
                begin
                    if (rst_pin_s)
                    begin
                        state_reg <= ST_RUN;
                    end
                    else if (exec_stop)
                    begin
                        state_reg <= ST_STANDBY;
                    end
                    else if (exec)
                    begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_STANDBY:
                begin
                    // reset high keeps standby; its fall, or a byte with reset low, clears it
                    if (byte_evt && !rst_pin_s)
                    begin
                        state_reg <= ST_BUSY;
                    end
                end
                default:
                begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            proc_cnt_reg <= 4'h0;
        end
        else if (byte_evt)
        begin
            proc_cnt_reg <= 4'(lcsc_pkg::PROC_CYCLES - 1);
        end
        else if (proc_cnt_reg != 4'h0)
        begin
            proc_cnt_reg <= proc_cnt_reg - 4'h1;
        end
    end

    // busy ends with processing, or at once when reset swallows the byte
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            done_tgl_reg <= 1'b0;
        end
        else if (exec || (byte_evt && rst_pin_s) || (state_reg == ST_BUSY && rst_pin_s))
        begin
            done_tgl_reg <= ~done_tgl_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dp_mode_reg <= lcsc_pkg::DPM_AUTO_INC;
            acc_mode_reg <= lcsc_pkg::ACC_WRITE;
            ptr_reg <= lcsc_pkg::PTR_RESET;
            disp_on_reg <= 1'b0;
        end
        else if (rst_pin_s)
        begin
            dp_mode_reg <= lcsc_pkg::DPM_AUTO_INC;
            acc_mode_reg <= lcsc_pkg::ACC_WRITE;
            ptr_reg <= lcsc_pkg::PTR_RESET;
            disp_on_reg <= 1'b0;
        end
        else if (exec_stop)
        begin
            // only the processing and access modes move; display setup kept
            dp_mode_reg <= lcsc_pkg::DPM_AUTO_INC;
            acc_mode_reg <= lcsc_pkg::ACC_WRITE;
        end
        else if (exec && link_byte_reg.cmd)
        begin
            if (in_range(link_byte_reg.data, lcsc_pkg::CMD_MODE_LO, lcsc_pkg::CMD_MODE_HI))
            begin
                acc_mode_reg <= link_byte_reg.data[lcsc_pkg::ACC_LSB +: 2];
                dp_mode_reg <= link_byte_reg.data[lcsc_pkg::DPM_LSB +: 2];
            end
            else if (in_range(link_byte_reg.data, lcsc_pkg::CMD_PTR_LO, lcsc_pkg::CMD_PTR_HI))
            begin
                ptr_reg <= link_byte_reg.data[lcsc_pkg::MEM_AW-1:0];
            end
            else if (link_byte_reg.data == lcsc_pkg::CMD_DISP_ON)
            begin
                disp_on_reg <= 1'b1;
            end
            else if (link_byte_reg.data == lcsc_pkg::CMD_DISP_OFF)
            begin
                disp_on_reg <= 1'b0;
            end
        end
        else if (mem_we)
        begin
            if (dp_mode_reg == lcsc_pkg::DPM_AUTO_INC)
            begin
                ptr_reg <= ptr_reg + 7'h01;
            end
            else if (dp_mode_reg == lcsc_pkg::DPM_AUTO_DEC)
            begin
                ptr_reg <= ptr_reg - 7'h01;
            end
        end
    end

    // reset never writes or clears the array, so data outlive it
    assign mem_we = exec && !link_byte_reg.cmd && (acc_mode_reg == lcsc_pkg::ACC_WRITE);

    // emulated clock mask: timing logic simply stops advancing
    assign clk_run = ~in_standby;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_cnt_reg <= '0;
            alt_phase_reg <= 1'b0;
        end
        else if (clk_run && !rst_pin_s)
        begin
            frame_cnt_reg <= frame_cnt_reg + 1'b1;
            if (&frame_cnt_reg)
            begin
                alt_phase_reg <= ~alt_phase_reg;
            end
        end
    end

    lcsc_mem u_mem (
        .clk(clk),
        .rst_b(rst_b),
        .we(mem_we),
        .waddr(ptr_reg),
        .wdata(link_byte_reg.data),
        .re(clk_run),
        .raddr(frame_cnt_reg[lcsc_pkg::MEM_AW-1:0]),
        .rdata(lcd_col_data)
    );

    // frozen level leaves dc across the panel; host must lift the bias pin
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lcd_level_reg <= lcsc_pkg::LVL_MID;
        end
        else if (rst_pin_s)
        begin
            lcd_level_reg <= lcsc_pkg::LVL_MID;
        end
        else if (in_standby)
        begin
            lcd_level_reg <= lcd_level_reg;
        end
        else if (!disp_on_reg)
        begin
            lcd_level_reg <= lcsc_pkg::LVL_MID;
        end
        else
        begin
            lcd_level_reg <= alt_phase_reg ? lcsc_pkg::LVL_HI : lcsc_pkg::LVL_LO;
        end
    end

    // toggles differ only between the byte's last strobe edge (second parallel, eighth serial) and end of processing
    assign busy_n = ~(byte_tgl_reg ^ done_tgl_reg);
    assign busy_oe = cs_act_s;
    assign standby = in_standby;
    assign lcd_timing_clk_en = clk_run;
    assign clk_ctrl_clk_en = clk_run;
    assign lcd_level = lcd_level_reg;
    assign data_processing_mode_field = dp_mode_reg;
    assign access_mode = acc_mode_reg;
    assign display_on = disp_on_reg;

    // ---------------- checks ----------------
    a_stop_only_entry: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(in_standby) |-> $past(exec_stop))
        else $error("standby entered without stop command");

    a_busy_high_entry: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(in_standby) |-> busy_n)
        else $error("standby entered while busy low");

    a_timing_frozen: assert property (@(posedge clk) disable iff (!rst_b)
        (in_standby && $past(in_standby)) |-> ($stable(frame_cnt_reg) && !lcd_timing_clk_en))
        else $error("timing logic advanced in standby");

    a_mode_forced: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(in_standby) |-> (dp_mode_reg == lcsc_pkg::DPM_AUTO_INC))
        else $error("processing mode not cleared on standby entry");

    a_config_kept: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(in_standby) |-> ($stable(cfg_reg) && $stable(disp_on_reg) && $stable(ptr_reg)))
        else $error("settings changed on standby entry");

    a_byte_wakes: assert property (@(posedge clk) disable iff (!rst_b)
        (in_standby && byte_evt && !rst_pin_s) |=> (state_reg == ST_BUSY))
        else $error("written byte did not end standby");

    a_reset_wakes: assert property (@(posedge clk) disable iff (!rst_b)
        (in_standby && rst_fall) |=> !in_standby)
        else $error("reset fall did not end standby");

    a_level_held: assert property (@(posedge clk) disable iff (!rst_b)
        (in_standby && $past(in_standby) && !rst_pin_s) |-> $stable(lcd_level_reg))
        else $error("lcd level moved in standby");

    a_reset_level: assert property (@(posedge clk) disable iff (!rst_b)
        rst_pin_s |=> (lcd_level == lcsc_pkg::LVL_MID))
        else $error("lcd not at reset level under reset");

    a_mem_untouched: assert property (@(posedge clk) disable iff (!rst_b)
        rst_pin_s |-> !mem_we)
        else $error("memory written during reset");

    a_busy_bounded: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(busy_n) |-> ##[1:16] busy_n)
        else $error("busy stuck low");

    a_addr_first: assert property (@(posedge nibble_strobe_n) disable iff (!link_rst_b)
        (addr_phase_reg && cfg_reg.cae && !cfg_reg.par && last_edge) |=> ($stable(byte_tgl_reg) && !addr_phase_reg))
        else $error("address byte taken as data");

    a_ser_eighth: assert property (@(posedge nibble_strobe_n) disable iff (!link_rst_b)
        (!cfg_reg.par && byte_done) |=> (byte_tgl_reg != $past(byte_tgl_reg)))
        else $error("serial byte not completed at eighth edge");

    a_par_second: assert property (@(posedge clk) disable iff (!rst_b)
        (cfg_reg.par && (byte_tgl_reg != $past(byte_tgl_reg))) |-> !busy_n)
        else $error("busy not low after second strobe");
endmodule
`default_nettype wire

// ### test/lcsc_host.sv
`timescale 1ns/100ps
`default_nettype none
module lcsc_host (
    output logic nibble_strobe_n,
    output logic cs_n,
    output logic cmd_data_sel,
    output logic [3:0] data_in,
    output logic bias_lift
);
    localparam int HALF_NS = 6;
    logic par_reg;
    initial
    begin
        nibble_strobe_n = 1'b1;
        cs_n = 1'b1;
        cmd_data_sel = 1'b0;
        data_in = 4'h0;
        bias_lift = 1'b0;
        par_reg = 1'b0;
    end
    // straps stay on the bus until the next selection
    task automatic set_straps(input logic [3:0] v, input logic par);
        data_in = v;
        par_reg = par;
    endtask
    // link clock only moves inside a transfer
    task automatic strobe(input logic [3:0] v);
        nibble_strobe_n = 1'b0;
        data_in = v;
        #HALF_NS;
        nibble_strobe_n = 1'b1;
        #HALF_NS;
    endtask
    task automatic send_byte(input logic cmd, input logic [7:0] b);
        bias_lift = cmd && (b == lcsc_pkg::CMD_STOP);
        cmd_data_sel = cmd;
        if (par_reg)
        begin
            strobe(b[7:4]);
            strobe(b[3:0]);
        end
        else
        begin
            for (int i = 7; i >= 0; i--)
                strobe({~data_in[3:1], b[i]});
        end
        #HALF_NS;
        data_in = ~data_in;
    endtask
    task automatic select_chip(input logic [1:0] addr, input logic addr_on);
        cs_n = 1'b0;
        #HALF_NS;
        if (addr_on && par_reg)
            strobe({2'h0, addr});
        else if (addr_on)
            send_byte(1'b0, {6'h00, addr});
    endtask
    // released lines must not keep a plausible value
    task automatic deselect;
        cs_n = 1'b1;
        data_in = ~data_in;
        #HALF_NS;
    endtask
endmodule
`default_nettype wire

// ### test/lcsc_standby_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lcsc_standby_ctrl_tb;
    logic clk = 1'b0;
    logic clk_run = 1'b1;
    logic rst_b = 1'b0;
    logic reset_in = 1'b0;
    logic [1:0] pins = 2'h0;
    int bad_count = 0;
    int n_compared = 0;
    wire logic strobe_n;
    wire logic cs_n;
    wire logic cmd_sel;
    wire logic [3:0] data_in;
    wire logic bias_lift;
    logic busy_n, busy_oe, standby, lt_en, cc_en, display_on;
    logic [1:0] lcd_level, mode, access;
    logic [1:0] lvl;
    logic [7:0] col;
    // a halted clock just stops toggling
    always #4 clk = clk_run ? ~clk : clk;
    lcsc_host lcsc_host_i (.nibble_strobe_n(strobe_n), .cs_n(cs_n), .cmd_data_sel(cmd_sel),
        .data_in(data_in), .bias_lift(bias_lift));
    lcsc_standby_ctrl lcsc_standby_ctrl_i (.clk(clk), .rst_b(rst_b), .nibble_strobe_n(strobe_n),
        .cs_n(cs_n), .cmd_data_sel(cmd_sel), .data_in(data_in), .chip_addr_pin_low(pins[0]),
        .chip_addr_pin_high(pins[1]), .reset_in(reset_in), .busy_n(busy_n), .busy_oe(busy_oe),
        .standby(standby), .lcd_timing_clk_en(lt_en), .clk_ctrl_clk_en(cc_en), .lcd_level(lcd_level),
        .lcd_col_data(col), .data_processing_mode_field(mode), .access_mode(access),
        .display_on(display_on));
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic timed_out(input string what);
        bad_count++;
        $display("wrong value %s expected done seen timeout", what);
        complete_run();
    endtask
    task automatic wait_busy;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk);
            #1;
            if (busy_n === 1'b1)
                return;
        end
        timed_out("busy_n");
    endtask
    task automatic wait_standby(input logic v);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk);
            #1;
            if (standby === v)
                return;
        end
        timed_out("standby");
    endtask
    // byte, then busy low at its last edge and back high later
    task automatic send(input logic cmd, input logic [7:0] b);
        lcsc_host_i.send_byte(cmd, b);
        #1;
        check("busy_n low", 8'(busy_n), 8'h00);
        wait_busy();
    endtask
    task automatic stop;
        send(1'b1, lcsc_pkg::CMD_STOP);
        check("standby on", 8'(standby), 8'h01);
    endtask
    task automatic pulse_reset;
        @(posedge clk);
        reset_in <= 1'b1;
        cycles(4);
        reset_in <= 1'b0;
        cycles(6);
    endtask
    task automatic t_reset_values;
        #1;
        check("busy_n", 8'(busy_n), 8'h01);
        check("busy_oe", 8'(busy_oe), 8'h00);
        check("standby", 8'(standby), 8'h00);
        check("clk enables", 8'({lt_en, cc_en}), 8'h03);
        check("lcd_level", 8'(lcd_level), 8'(lcsc_pkg::LVL_MID));
        check("mode", 8'(mode), 8'(lcsc_pkg::DPM_AUTO_INC));
        check("access", 8'(access), 8'(lcsc_pkg::ACC_WRITE));
    endtask
    task automatic t_settings;
        lcsc_host_i.select_chip(2'h0, 1'b0);
        send(1'b1, 8'h65);
        // lands at pointer 0, read back after the reset exit
        send(1'b0, 8'h5a);
        send(1'b1, lcsc_pkg::CMD_DISP_ON);
        check("mode dec", 8'(mode), 8'(lcsc_pkg::DPM_AUTO_DEC));
        check("display_on", 8'(display_on), 8'h01);
        check("no standby", 8'(standby), 8'h00);
        check("busy_oe", 8'(busy_oe), 8'h01);
    endtask
    task automatic t_stop_serial;
        lcsc_host_i.send_byte(1'b1, lcsc_pkg::CMD_STOP);
        #1;
        check("stop busy low", 8'(busy_n), 8'h00);
        check("standby early", 8'(standby), 8'h00);
        wait_busy();
        lvl = lcd_level;
        check("standby at busy high", 8'(standby), 8'h01);
        check("clk enables off", 8'({lt_en, cc_en}), 8'h00);
        check("mode reset", 8'(mode), 8'(lcsc_pkg::DPM_AUTO_INC));
        check("access write", 8'(access), 8'(lcsc_pkg::ACC_WRITE));
        check("display kept", 8'(display_on), 8'h01);
        // long enough for a running frame counter to wrap and flip the level
        cycles(16400);
        check("level held", 8'(lcd_level), 8'(lvl));
    endtask
    // the waking byte is executed as well
    task automatic t_wake_serial;
        lcsc_host_i.send_byte(1'b1, 8'h66);
        wait_standby(1'b0);
        wait_busy();
        check("woken mode", 8'(mode), 8'h02);
        check("clk enables on", 8'({lt_en, cc_en}), 8'h03);
    endtask
    task automatic t_reset_exit;
        logic kept;
        stop();
        @(posedge clk);
        reset_in <= 1'b1;
        lcsc_host_i.deselect();
        lcsc_host_i.set_straps(4'h2, 1'b1);
        pins <= 2'h2;
        cycles(6);
        check("reset level", 8'(lcd_level), 8'(lcsc_pkg::LVL_MID));
        check("standby kept", 8'(standby), 8'h01);
        clk_run = 1'b0;
        #100;
        clk_run = 1'b1;
        cycles(2);
        reset_in <= 1'b0;
        wait_standby(1'b0);
        cycles(6);
        // scan one full pass of the read address for the byte written earlier
        kept = 1'b0;
        for (int i = 0; i < 140 && !kept; i++)
        begin
            @(posedge clk);
            #1;
            kept = (col === 8'h5a);
        end
        check("memory kept", 8'(kept), 8'h01);
    endtask
    task automatic t_parallel;
        lcsc_host_i.select_chip(2'h2, 1'b1);
        stop();
        lcsc_host_i.send_byte(1'b1, 8'h65);
        wait_standby(1'b0);
        wait_busy();
        check("par mode", 8'(mode), 8'h01);
    endtask
    task automatic t_serial_addr;
        lcsc_host_i.deselect();
        lcsc_host_i.set_straps(4'h4, 1'b0);
        pins <= 2'h1;
        pulse_reset();
        lcsc_host_i.select_chip(2'h1, 1'b1);
        stop();
        lcsc_host_i.deselect();
        lcsc_host_i.select_chip(2'h1, 1'b1);
        cycles(10);
        check("address byte no wake", 8'(standby), 8'h01);
        lcsc_host_i.send_byte(1'b1, 8'h66);
        wait_standby(1'b0);
        wait_busy();
    endtask
    initial
    begin
        cycles(20);
        rst_b <= 1'b1;
        cycles(2);
        t_reset_values();
        t_settings();
        t_stop_serial();
        t_wake_serial();
        t_reset_exit();
        t_parallel();
        t_serial_addr();
        complete_run();
    end
endmodule
`default_nettype wire
